/* File: hdl/flk_top.v */
// Flash lock state and reset-time initialisation with APB registers.
// Assumes a config store answering one cycle after a read enable, and a
// separate erase and program engine with start, done and abort lines.
//
// Summary of operation
// RULE1 - Load lock register from stored byte, report
// RULE2 - Lock register holds four permission fields
// RULE3 - Locked special mode allows only three commands
// RULE4 - New stored byte acts after next reset
// RULE5 - Requester unprotects config area before reprogramming
// RULE6 - Key verify runs only when permitted
// RULE7 - Matching key sets lock field unlocked
// RULE8 - Uniform zero or one keys never unlock
// RULE9 - One failed compare blocks verify until reset
// RULE10 - Unlock touches only the volatile register
// RULE11 - Reset restores lock from stored byte
// RULE12 - Key verify leaves protection settings unchanged
// RULE13 - After unlock allow config sector rewrite
// RULE14 - Reset runs load of all configuration
// RULE15 - Done flag reads clear during initialisation
// RULE16 - Stall CPU flash access during initialisation
// RULE17 - Set done flag when initialisation ends
// RULE18 - Reset aborts running command at once
// RULE19 - No command resumes after reset
// RULE20 - Requester writes code, key, clears done
// RULE21 - Access error on any verify failure
// RULE22 - Lock state output follows register directly
`timescale 1ns/1ps
`include "flk_defs.vh"

module flk_top (
   input  wire        clk_sys_i,
   input  wire        reset_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   input  wire [3:0]  pstrb_i,
   output wire [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   input  wire        special_mode_i,
   output wire        cfg_rd_en_o,
   output wire [2:0]  cfg_rd_addr_o,
   input  wire [31:0] cfg_rd_data_i,
   output wire        cpu_stall_o,
   output wire [7:0]  lock_info_o,
   output wire [1:0]  lock_state_o,
   output wire        cfg_sector_open_o,
   output wire [31:0] protect_o,
   output wire        eng_start_o,
   output wire [7:0]  eng_code_o,
   output wire        eng_abort_o,
   input  wire        eng_done_i,
   input  wire        eng_err_i
);

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam ST_LOAD = 2'h0;
   localparam ST_IDLE = 2'h1;
   localparam ST_EXEC = 2'h2;
   localparam ST_ENG  = 2'h3;
   localparam [7:0] LOCK_RST_VAL = `FLK_LOCK_RST;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   reg [1:0]  state_reg;
   reg [2:0]  idx_reg;
   reg        rd_pend_reg;
   reg        cfg_rd_en_reg;
   reg [2:0]  cfg_rd_addr_reg;
   reg [63:0] key_reg;
   reg [31:0] protect_reg;
   reg [7:0]  option_reg;
   reg [31:0] blkcfg_reg;
   reg [7:0]  lock_reg;
   reg [1:0]  lock_state_reg;
   reg [7:0]  lock_info_reg;
   reg        open_reg;
   reg        done_reg;
   reg        acc_err_reg;
   reg        lockout_reg;
   reg        stall_reg;
   reg [31:0] cmd0_reg;
   reg [31:0] cmd1_reg;
   reg [31:0] cmd2_reg;
   reg        eng_start_reg;
   reg [7:0]  eng_code_reg;
   reg        eng_abort_reg;
   reg [31:0] prdata_reg;
   reg        pready_reg;
   reg        pslverr_reg;
   reg [31:0] rd_next;
   reg        bad_next;

   wire       key_match;
   wire       key_invalid;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function lock_open;
      input [1:0] f;
      begin
         lock_open = (f == `FLK_LOCK_OPEN);
      end
   endfunction

   function cmd_permitted;
      input [7:0] code;
      input       locked;
      input       special;
      begin
         if (!locked || !special) begin
            cmd_permitted = 1'b1;
         end else begin
            cmd_permitted = (code == `FLK_CMD_ERASE_ALL) ||
                            (code == `FLK_CMD_ERASE_ALLU) ||
                            (code == `FLK_CMD_READ_ONES);
         end
      end
   endfunction

   function [31:0] strb_merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0]  st;
      integer      i;
      begin
         strb_merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (st[i]) begin
               strb_merge[i*8 +: 8] = wd[i*8 +: 8];
            end
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // Key comparison
   // ----------------------------------------------------------------
   flk_key_cmp u_key_cmp (
      .stored_key_i (key_reg),
      .given_key_i  ({cmd1_reg, cmd2_reg}),
      .match_o      (key_match),
      .invalid_o    (key_invalid)
   );

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire apb_setup = psel_i & penable_i & ~pready_reg;
   wire apb_wr    = psel_i & penable_i & pready_reg & pwrite_i & ~pslverr_reg;
   wire wr_status = apb_wr & (paddr_i == `FLK_OFS_STATUS) & pstrb_i[0];
   wire wr_cmd    = apb_wr & done_reg & (state_reg == ST_IDLE);
   wire launch    = wr_status & pwdata_i[`FLK_ST_DONE] & done_reg & (state_reg == ST_IDLE);
   wire err_clear = wr_status & pwdata_i[`FLK_ST_ACCESS_ERROR_FLAG];

   always @* begin
      rd_next  = 32'h00000000;
      bad_next = 1'b0;
      if (paddr_i == `FLK_OFS_STATUS) begin
         rd_next[`FLK_ST_DONE]   = done_reg; // see RULE15
         rd_next[`FLK_ST_ACCESS_ERROR_FLAG] = acc_err_reg;
      end else if (paddr_i == `FLK_OFS_LOCK) begin
         rd_next[7:0] = lock_reg; // see RULE2
      end else if (paddr_i == `FLK_OFS_OPTION) begin
         rd_next[7:0] = option_reg;
      end else if (paddr_i == `FLK_OFS_PROTECT) begin
         rd_next = protect_reg;
      end else if (paddr_i == `FLK_OFS_CMD0) begin
         rd_next = cmd0_reg;
      end else if (paddr_i == `FLK_OFS_CMD1) begin
         rd_next = cmd1_reg;
      end else if (paddr_i == `FLK_OFS_CMD2) begin
         rd_next = cmd2_reg;
      end else if (paddr_i == `FLK_OFS_BLKCFG) begin
         rd_next = blkcfg_reg;
      end else begin
         bad_next = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // APB response
   // ----------------------------------------------------------------
   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end else begin
         pready_reg <= apb_setup;
         if (apb_setup) begin
            prdata_reg  <= pwrite_i ? 32'h00000000 : rd_next;
            pslverr_reg <= bad_next;
         end else begin
            pslverr_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Command object registers
   // ----------------------------------------------------------------
   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         cmd0_reg <= 32'h00000000;
         cmd1_reg <= 32'h00000000;
         cmd2_reg <= 32'h00000000;
      end else if (wr_cmd) begin
         if (paddr_i == `FLK_OFS_CMD0) begin
            cmd0_reg <= strb_merge(cmd0_reg, pwdata_i, pstrb_i); // see RULE20
         end else if (paddr_i == `FLK_OFS_CMD1) begin
            cmd1_reg <= strb_merge(cmd1_reg, pwdata_i, pstrb_i); // see RULE20
         end else if (paddr_i == `FLK_OFS_CMD2) begin
            cmd2_reg <= strb_merge(cmd2_reg, pwdata_i, pstrb_i); // see RULE20
         end
      end
   end

   // ----------------------------------------------------------------
   // Initialisation and command control
   // ----------------------------------------------------------------
   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_reg       <= ST_LOAD;    // see RULE14
         idx_reg         <= 3'h0;
         rd_pend_reg     <= 1'b0;
         cfg_rd_en_reg   <= 1'b0;
         cfg_rd_addr_reg <= 3'h0;
         key_reg         <= 64'h0000000000000000;
         protect_reg     <= 32'h00000000;
         option_reg      <= 8'h00;
         blkcfg_reg      <= 32'h00000000;
         lock_reg        <= `FLK_LOCK_RST;       // see RULE11
         lock_state_reg  <= LOCK_RST_VAL[1:0];
         lock_info_reg   <= `FLK_LOCK_RST;
         open_reg        <= 1'b0;
         done_reg        <= 1'b0;       // see RULE15
         acc_err_reg     <= 1'b0;
         lockout_reg     <= 1'b0;       // see RULE9
         stall_reg       <= 1'b1;       // see RULE16
         eng_start_reg   <= 1'b0;       // see RULE19
         eng_code_reg    <= 8'h00;
         eng_abort_reg   <= 1'b1;       // see RULE18
      end else begin
         eng_abort_reg <= 1'b0;
         eng_start_reg <= 1'b0;         // see RULE19
         if (err_clear) begin
            acc_err_reg <= 1'b0;
         end
         if (launch) begin
            done_reg  <= 1'b0;
            state_reg <= ST_EXEC;
         end
         case (state_reg)
            ST_LOAD: begin
               if (!rd_pend_reg) begin
                  cfg_rd_en_reg   <= 1'b1;
                  cfg_rd_addr_reg <= idx_reg;
                  rd_pend_reg     <= 1'b1;
               end else if (cfg_rd_en_reg) begin
                  cfg_rd_en_reg <= 1'b0;
               end else begin
                  rd_pend_reg <= 1'b0;
                  if (idx_reg == `FLK_CFG_KEY_LO) begin
                     key_reg[63:32] <= cfg_rd_data_i;
                  end else if (idx_reg == `FLK_CFG_KEY_HI) begin
                     key_reg[31:0] <= cfg_rd_data_i;
                  end else if (idx_reg == `FLK_CFG_PROTECT) begin
                     protect_reg <= cfg_rd_data_i;             // see RULE14
                  end else if (idx_reg == `FLK_CFG_OPT_LOCK) begin
                     option_reg     <= cfg_rd_data_i[15:8];    // see RULE14
                     lock_reg       <= cfg_rd_data_i[7:0];     // see RULE1
                     lock_state_reg <= cfg_rd_data_i[1:0];     // see RULE22
                     lock_info_reg  <= cfg_rd_data_i[7:0];     // see RULE1
                     open_reg       <= lock_open(cfg_rd_data_i[1:0]);
                  end else begin
                     blkcfg_reg <= cfg_rd_data_i;              // see RULE14
                  end
                  if (idx_reg == `FLK_CFG_LAST) begin
                     state_reg <= ST_IDLE;
                     done_reg  <= 1'b1;                        // see RULE17
                     stall_reg <= 1'b0;                        // see RULE16
                  end else begin
                     idx_reg <= idx_reg + 3'h1;
                  end
               end
            end
            ST_IDLE: begin
               // Stored byte is only read during load; see RULE4
            end
            ST_EXEC: begin
               state_reg <= ST_IDLE;
               done_reg  <= 1'b1;
               if (!cmd_permitted(cmd0_reg[7:0], ~lock_open(lock_reg[`FLK_F_LOCK]),
                                  special_mode_i)) begin
                  acc_err_reg <= 1'b1;                         // see RULE3
               end else if (cmd0_reg[7:0] == `FLK_CMD_VERIFY) begin
                  if (lock_reg[`FLK_F_KEY] != `FLK_KEY_ON) begin
                     acc_err_reg <= 1'b1;                      // see RULE6
                  end else if (lockout_reg) begin
                     acc_err_reg <= 1'b1;                      // see RULE9
                  end else if (!key_match) begin
                     acc_err_reg <= 1'b1;                      // see RULE21
                     lockout_reg <= 1'b1;                      // see RULE9
                  end else begin
                     // Volatile copy only; protection untouched, see RULE10 and RULE12
                     lock_reg[`FLK_F_LOCK] <= `FLK_LOCK_OPEN;  // see RULE7
                     lock_state_reg        <= `FLK_LOCK_OPEN;  // see RULE22
                     lock_info_reg         <= {lock_reg[7:2], `FLK_LOCK_OPEN};
                     open_reg              <= 1'b1;            // see RULE13
                  end
               end else begin
                  done_reg      <= 1'b0;
                  eng_start_reg <= 1'b1;
                  eng_code_reg  <= cmd0_reg[7:0];
                  state_reg     <= ST_ENG;
               end
            end
            ST_ENG: begin
               if (eng_done_i) begin
                  done_reg  <= 1'b1;
                  state_reg <= ST_IDLE;
                  if (eng_err_i) begin
                     acc_err_reg <= 1'b1;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata_o          = prdata_reg;
   assign pready_o          = pready_reg;
   assign pslverr_o         = pslverr_reg;
   assign cfg_rd_en_o       = cfg_rd_en_reg;
   assign cfg_rd_addr_o     = cfg_rd_addr_reg;
   assign cpu_stall_o       = stall_reg;
   assign lock_info_o       = lock_info_reg;
   assign lock_state_o      = lock_state_reg;
   assign cfg_sector_open_o = open_reg;
   assign protect_o         = protect_reg;   // see RULE12
   assign eng_start_o       = eng_start_reg;
   assign eng_code_o        = eng_code_reg;
   assign eng_abort_o       = eng_abort_reg;

endmodule // flk_top

/* File: hdl/flk_defs.vh */
// Constants for the flash lock and boot initialisation block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef FLK_DEFS_VH
`define FLK_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FLK_OFS_STATUS     8'h00
`define FLK_OFS_LOCK       8'h04
`define FLK_OFS_OPTION     8'h08
`define FLK_OFS_PROTECT    8'h0C
`define FLK_OFS_CMD0       8'h10
`define FLK_OFS_CMD1       8'h14
`define FLK_OFS_CMD2       8'h18
`define FLK_OFS_BLKCFG     8'h1C

// ----------------------------------------------------------------
// Status register bits
// ----------------------------------------------------------------
`define FLK_ST_DONE        7
`define FLK_ST_ACCESS_ERROR_FLAG      5

// ----------------------------------------------------------------
// Lock register fields and encodings
// ----------------------------------------------------------------
`define FLK_F_KEY          7:6
`define FLK_F_MASS         5:4
`define FLK_F_FACT         3:2
`define FLK_F_LOCK         1:0
`define FLK_LOCK_OPEN      2'h2
`define FLK_KEY_ON         2'h2
`define FLK_LOCK_RST       8'hFF

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define FLK_CMD_VERIFY     8'h45
`define FLK_CMD_ERASE_ALL  8'h44
`define FLK_CMD_ERASE_ALLU 8'h49
`define FLK_CMD_READ_ONES  8'h01

// ----------------------------------------------------------------
// Configuration area word addresses
// ----------------------------------------------------------------
`define FLK_CFG_KEY_LO     3'h0
`define FLK_CFG_KEY_HI     3'h1
`define FLK_CFG_PROTECT    3'h2
`define FLK_CFG_OPT_LOCK   3'h3
`define FLK_CFG_BLKCFG     3'h4
`define FLK_CFG_LAST       3'h4

`endif

/* File: hdl/flk_key_cmp.v */
// Backdoor key comparator: presented key against stored key.
// Assumes both keys are stable while the result is used.
`timescale 1ns/1ps

module flk_key_cmp (
   input  wire [63:0] stored_key_i,
   input  wire [63:0] given_key_i,
   output wire        match_o,
   output wire        invalid_o
);

   // ----------------------------------------------------------------
   // All-zero or all-one test
   // ----------------------------------------------------------------
   function uniform;
      input [63:0] k;
      begin
         uniform = (k == 64'h0000000000000000) || (k == 64'hFFFFFFFFFFFFFFFF);
      end
   endfunction

   assign invalid_o = uniform(stored_key_i) | uniform(given_key_i); // see RULE8
   assign match_o   = (stored_key_i == given_key_i) & ~invalid_o;   // see RULE8

endmodule // flk_key_cmp

/* File: verif/flk_cfg_model.sv */
// Config store and command engine model facing flk_top.
// Assumes the bench sets the stored words before each reset.
`timescale 1ns/1ps

module flk_cfg_model (
   input  wire        clk_sys_i,
   input  wire        rd_en_i,
   input  wire [2:0]  rd_addr_i,
   input  wire [63:0] key_i,
   input  wire [31:0] prot_i,
   input  wire [31:0] word3_i,
   input  wire        start_i,
   input  wire        abort_i,
   output reg  [31:0] rd_data_o = 32'h0,
   output reg         done_o = 1'b0
);
   reg [3:0] cnt_reg = 4'h0;

   // Word valid one cycle after enable, scrambled otherwise
   always @(posedge clk_sys_i) begin
      if (rd_en_i) begin
         case (rd_addr_i)
            3'h0: rd_data_o <= key_i[63:32];
            3'h1: rd_data_o <= key_i[31:0];
            3'h2: rd_data_o <= prot_i;
            3'h3: rd_data_o <= word3_i;
            default: rd_data_o <= 32'h0000_0101;
         endcase
      end else begin
         rd_data_o <= ~rd_data_o;
      end
      // Engine ends after six cycles, abort drops it
      done_o <= !abort_i && cnt_reg == 4'h1;
      if (abort_i)
         cnt_reg <= 4'h0;
      else if (start_i)
         cnt_reg <= 4'h6;
      else if (cnt_reg != 4'h0)
         cnt_reg <= cnt_reg - 4'h1;
   end
endmodule // flk_cfg_model

/* File: verif/flk_top_monitor.sv */
// Port checker for flk_top, bound into every instance.
// Assumes one system clock and synchronous reset.
`timescale 1ns/1ps

module flk_top_monitor (
   input wire        clk_sys_i,
   input wire        reset_i,
   input wire        pwrite_i,
   input wire [7:0]  paddr_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        special_mode_i,
   input wire        cfg_rd_en_o,
   input wire [2:0]  cfg_rd_addr_o,
   input wire        cpu_stall_o,
   input wire [7:0]  lock_info_o,
   input wire [1:0]  lock_state_o,
   input wire        cfg_sector_open_o,
   input wire [31:0] protect_o,
   input wire        eng_start_o,
   input wire [7:0]  eng_code_o,
   input wire        eng_abort_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   sequence s_rel; $fell(reset_i); endsequence
   sequence s_hold; cpu_stall_o [*8] ##1 cpu_stall_o [*7]; endsequence

   a_reset_values: assert property (s_rel |-> (cpu_stall_o && eng_abort_o && lock_info_o == 8'hFF) ##2 !eng_abort_o)
      else $error("reset state wrong");
   a_stall_span: assert property (s_rel |-> s_hold ##1 !cpu_stall_o)
      else $error("stall span wrong");
   a_cfg_first: assert property (s_rel |-> ##[0:2] (cfg_rd_en_o && cfg_rd_addr_o == 3'h0))
      else $error("first config read missing");
   a_cfg_order: assert property (cfg_rd_en_o && cfg_rd_addr_o != 3'h4 |->
      ##3 (cfg_rd_en_o && cfg_rd_addr_o == $past(cfg_rd_addr_o, 3) + 3'h1))
      else $error("config read order wrong");
   a_done_clear: assert property (pready_o && !pwrite_i && paddr_i == 8'h00 && cpu_stall_o |-> !prdata_o[7])
      else $error("done flag set during init");
   a_lock_out: assert property (lock_state_o == lock_info_o[1:0] && cfg_sector_open_o == (lock_info_o[1:0] == 2'h2))
      else $error("lock outputs disagree");
   a_unlock_only: assert property (!cpu_stall_o && !$past(cpu_stall_o) && $changed(lock_info_o) |->
      lock_state_o == 2'h2 && lock_info_o[7:2] == $past(lock_info_o[7:2]))
      else $error("lock register changed wrongly");
   a_protect_hold: assert property (!cpu_stall_o |-> $stable(protect_o))
      else $error("protection changed");
   a_no_resume: assert property (cpu_stall_o |-> !eng_start_o)
      else $error("engine started during init");
   a_special_codes: assert property (eng_start_o && special_mode_i && lock_state_o != 2'h2 |->
      eng_code_o inside {8'h44, 8'h49, 8'h01})
      else $error("command not allowed in special mode");
endmodule // flk_top_monitor

bind flk_top flk_top_monitor u_mon (.clk_sys_i, .reset_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o,
   .special_mode_i, .cfg_rd_en_o, .cfg_rd_addr_o, .cpu_stall_o, .lock_info_o, .lock_state_o,
   .cfg_sector_open_o, .protect_o, .eng_start_o, .eng_code_o, .eng_abort_o);

/* File: verif/tb_flash_lock_and_boot_init.sv */
// Self-checking bench for flk_top with store and engine model.
// Assumes flk_defs.vh is on the include path.
`timescale 1ns/1ps
`include "flk_defs.vh"

module tb_flash_lock_and_boot_init;
   reg         clk_sys_i = 1'b0;
   reg         reset_i = 1'b1;
   reg         psel_i = 1'b0;
   reg         penable_i = 1'b0;
   reg         pwrite_i = 1'b0;
   reg  [7:0]  paddr_i = 8'h00;
   reg  [31:0] pwdata_i = 32'h0;
   reg         special_mode_i = 1'b0;
   reg  [63:0] key_m = 64'h0;
   reg  [31:0] prot_m = 32'h0;
   reg  [31:0] word3_m = 32'h0;
   wire [31:0] prdata_o, cfg_rd_data_i, protect_o;
   wire        pready_o, pslverr_o, cfg_rd_en_o, cpu_stall_o, cfg_sector_open_o;
   wire        eng_start_o, eng_abort_o, eng_done_i;
   wire [2:0]  cfg_rd_addr_o;
   wire [7:0]  lock_info_o, eng_code_o;
   wire [1:0]  lock_state_o;
   integer     error_cnt = 0;
   integer     checks_done = 0;
   integer     seed = 32'h49bb;
   integer     starts = 0;
   integer     i;
   reg  [7:0]  last_code = 8'h00;
   reg  [31:0] d = 32'h0;
   reg  [32:0] exp_q[$];
   reg  [31:0] msk_q[$];
   reg  [7:0]  codes[0:4] = '{8'h44, 8'h49, 8'h01, 8'h45, 8'h10};

   always #50 clk_sys_i = ~clk_sys_i;

   flk_top u_dut (.clk_sys_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i(4'hF),
      .prdata_o, .pready_o, .pslverr_o, .special_mode_i, .cfg_rd_en_o, .cfg_rd_addr_o, .cfg_rd_data_i,
      .cpu_stall_o, .lock_info_o, .lock_state_o, .cfg_sector_open_o, .protect_o, .eng_start_o, .eng_code_o,
      .eng_abort_o, .eng_done_i, .eng_err_i(1'b0));
   flk_cfg_model u_cfg (.clk_sys_i, .rd_en_i(cfg_rd_en_o), .rd_addr_i(cfg_rd_addr_o), .key_i(key_m),
      .prot_i(prot_m), .word3_i(word3_m), .start_i(eng_start_o), .abort_i(eng_abort_o),
      .rd_data_o(cfg_rd_data_i), .done_o(eng_done_i));

   task check(input [31:0] seen, input [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Read results compared against the oldest note
   always @(posedge clk_sys_i) begin
      if (eng_start_o) begin
         last_code <= eng_code_o;
         starts <= starts + 1;
      end
      if (psel_i && penable_i && pready_o && !pwrite_i) begin
         check(prdata_o & msk_q[0], exp_q[0][31:0]);
         check({31'h0, pslverr_o}, {31'h0, exp_q[0][32]});
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end

   task apb(input wr, input [7:0] a, input [31:0] wd, input [31:0] exp, input [31:0] msk);
      integer n;
      n = 0;
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      if (!wr) begin
         exp_q.push_back({a > 8'h1C, exp & msk});
         msk_q.push_back(msk);
      end
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      @(posedge clk_sys_i);
      while (pready_o !== 1'b1 && n < 20) begin
         @(posedge clk_sys_i);
         n = n + 1;
      end
      if (n == 20)
         error_cnt = error_cnt + 1;
      d = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task launch(input [7:0] code, input [63:0] k, input [31:0] st);
      integer n;
      apb(1, `FLK_OFS_CMD1, k[63:32], 0, 0);
      apb(1, `FLK_OFS_CMD2, k[31:0], 0, 0);
      apb(1, `FLK_OFS_CMD0, {24'h0, code}, 0, 0);
      apb(1, `FLK_OFS_STATUS, 32'h80, 0, 0);
      n = 0;
      d = 32'h0;
      while (d[7] !== 1'b1 && n < 40) begin
         apb(0, `FLK_OFS_STATUS, 0, 0, 0);
         n = n + 1;
      end
      apb(0, `FLK_OFS_STATUS, 0, st, 32'hA0);
      apb(1, `FLK_OFS_STATUS, 32'h20, 0, 0);
   endtask

   task do_reset;
      integer n;
      reset_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      apb(0, `FLK_OFS_STATUS, 0, 0, 32'h80);
      n = 0;
      while (cpu_stall_o !== 1'b0 && n < 40) begin
         @(posedge clk_sys_i);
         n = n + 1;
      end
      check({31'h0, cpu_stall_o}, 32'h0);
      check({24'h0, lock_info_o}, {24'h0, word3_m[7:0]});
      apb(0, `FLK_OFS_STATUS, 0, 32'h80, 32'h80);
      apb(0, `FLK_OFS_LOCK, 0, word3_m, 32'hFF);
      apb(0, `FLK_OFS_OPTION, 0, word3_m >> 8, 32'hFF);
      apb(0, `FLK_OFS_PROTECT, 0, prot_m, 32'hFFFFFFFF);
      apb(0, `FLK_OFS_BLKCFG, 0, 32'h00000101, 32'hFFFFFFFF);
   endtask

   initial begin
      #(20000 * 100);
      error_cnt = error_cnt + 1;
      close_out;
   end

   initial begin
      key_m = {$random(seed), $random(seed)};
      prot_m = $random(seed);
      word3_m = $random(seed);
      word3_m[7:0] = 8'hBF;
      do_reset;
      apb(0, 8'h20, 0, 0, 0);
      $display("boot and map test done");
      special_mode_i <= 1'b1;
      for (i = 0; i < 5; i = i + 1) begin
         launch(codes[i], key_m, i < 3 ? 32'h80 : 32'hA0);
         if (i < 3)
            check({24'h0, last_code}, {24'h0, codes[i]});
      end
      special_mode_i <= 1'b0;
      launch(8'h10, key_m, 32'h80);
      check({24'h0, last_code}, 32'h10);
      $display("mode test done");
      do_reset;
      launch(`FLK_CMD_VERIFY, ~key_m, 32'hA0);
      launch(`FLK_CMD_VERIFY, key_m, 32'hA0);
      check({30'h0, lock_state_o}, 32'h3);
      do_reset;
      launch(`FLK_CMD_VERIFY, key_m, 32'h80);
      check({30'h0, lock_state_o}, 32'h2);
      check(protect_o, prot_m);
      check({31'h0, cfg_sector_open_o}, 32'h1);
      word3_m[7:0] = 8'h3F;
      apb(0, `FLK_OFS_LOCK, 0, 32'hBE, 32'hFF);
      do_reset;
      launch(`FLK_CMD_VERIFY, key_m, 32'hA0);
      $display("unlock test done");
      word3_m[7:0] = 8'hBF;
      for (i = 0; i < 2; i = i + 1) begin
         key_m = i ? ~64'h0 : 64'h0;
         do_reset;
         launch(`FLK_CMD_VERIFY, key_m, 32'hA0);
         check({30'h0, lock_state_o}, 32'h3);
      end
      apb(1, `FLK_OFS_CMD0, 32'h10, 0, 0);
      apb(1, `FLK_OFS_STATUS, 32'h80, 0, 0);
      i = 0;
      while (eng_start_o !== 1'b1 && i < 20) begin
         @(posedge clk_sys_i);
         i = i + 1;
      end
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      check({31'h0, eng_abort_o}, 32'h1);
      i = starts;
      do_reset;
      repeat (20) @(posedge clk_sys_i);
      check(starts, i);
      $display("abort test done");
      close_out;
   end
endmodule // tb_flash_lock_and_boot_init
